// *** shared/fqsb_pkg.sv ***
// Constants for the queue occupancy status bank.
// Assumes a 16-bit register port with an 8-bit register index.
//
// What this block does
// - Low-priority receive frame count at 0xB4, 9 bits
// - High-priority receive frame count at 0xB5, 9 bits
// - Transmit frame count at 0xB6, 9 bits
// - Transmit half-word level at 0xB7, 14 bits
// - Low-priority receive half-word level at 0xB8
// - High-priority receive half-word level at 0xB9
// - Four read/write scratch words at 0xDC-0xDF
package fqsb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int FRAME_CNT_W = 9;
  localparam int LEVEL_W = 14;
  localparam int NUM_COUNTS = 6;
  localparam int NUM_SCRATCH = 4;
  localparam int SCRATCH_IDX_W = 2;

  // Register indices; the six counters sit back to back
  localparam logic [7:0] RX_LOW_QUEUE_FRAME_COUNT_OFS = 8'hB4;
  localparam logic [7:0] RX_HIGH_QUEUE_FRAME_COUNT_OFS = 8'hB5;
  localparam logic [7:0] TX_QUEUE_FRAME_COUNT_OFS = 8'hB6;
  localparam logic [7:0] TX_QUEUE_HALFWORD_LEVEL_OFS = 8'hB7;
  localparam logic [7:0] RX_LOW_QUEUE_HALFWORD_LEVEL_OFS = 8'hB8;
  localparam logic [7:0] RX_HIGH_QUEUE_HALFWORD_LEVEL_OFS = 8'hB9;
  localparam logic [7:0] SCRATCH_WORD_FIRST_OFS = 8'hDC;
  localparam logic [7:0] SCRATCH_WORD_LAST_OFS = 8'hDF;

  // Counter slots, in register order
  localparam int SLOT_RX_LOW_FRAMES = 0;
  localparam int SLOT_RX_HIGH_FRAMES = 1;
  localparam int SLOT_TX_FRAMES = 2;
  localparam int SLOT_TX_LEVEL = 3;
  localparam int SLOT_RX_LOW_LEVEL = 4;
  localparam int SLOT_RX_HIGH_LEVEL = 5;
  localparam int FIRST_LEVEL_SLOT = 3;

  localparam logic [15:0] REG_RESET_VAL = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ_VAL = 16'h0000;
endpackage

// *** core/fqsb_updown_counter.sv ***
// Up/down occupancy counter for one queue measure.
// Assumes inc and dec are single-cycle pulses on clk.
`timescale 1ns/1ns
`default_nettype none
module fqsb_updown_counter #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Queue events
  input wire logic inc,
  input wire logic dec,
  // Occupancy
  output logic [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] count_r;
  } fqsb_cnt_state_t;

  fqsb_cnt_state_t st_r;
  fqsb_cnt_state_t st_nxt;

  // Elaboration check on the counter width
  if (WIDTH < 1 || WIDTH > fqsb_pkg::DATA_W) begin : g_bad_width
    $error("WIDTH must be between 1 and the data width");
  end

  ////////////////////////////////////////////////////////////////////////
  // Saturating at both ends keeps a stray event from wrapping the count
  always_comb begin
    st_nxt = st_r;
    if (inc && !dec && st_r.count_r != {WIDTH{1'b1}}) begin
      st_nxt.count_r = st_r.count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (dec && !inc && st_r.count_r != {WIDTH{1'b0}}) begin
      st_nxt.count_r = st_r.count_r - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count_r;
endmodule // fqsb_updown_counter
`default_nettype wire

// *** core/fqsb_status_bank.sv ***
// Queue occupancy status bank with four scratch words.
// Assumes the register port and queue events share clk; one access per cycle.
`timescale 1ns/1ns
`default_nettype none
module fqsb_status_bank #(
  parameter int FRAME_CNT_W = fqsb_pkg::FRAME_CNT_W,
  parameter int LEVEL_W = fqsb_pkg::LEVEL_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rd_valid,
  // Low-priority receive queue events
  input wire logic rx_low_frame_in,
  input wire logic rx_low_frame_out,
  input wire logic rx_low_halfword_in,
  input wire logic rx_low_halfword_out,
  // High-priority receive queue events
  input wire logic rx_high_frame_in,
  input wire logic rx_high_frame_out,
  input wire logic rx_high_halfword_in,
  input wire logic rx_high_halfword_out,
  // Transmit queue events
  input wire logic tx_frame_in,
  input wire logic tx_frame_out,
  input wire logic tx_halfword_in,
  input wire logic tx_halfword_out,
  // Status toward the host side
  output logic rx_frame_ready_flag
);
  typedef struct packed {
    logic [fqsb_pkg::NUM_SCRATCH-1:0][15:0] scratch_word_r;
    logic [15:0] rdata_r;
    logic rd_valid_r;
    logic ready_r;
  } fqsb_bank_state_t;

  fqsb_bank_state_t st_r;
  fqsb_bank_state_t st_nxt;

  logic [fqsb_pkg::NUM_COUNTS-1:0] cnt_inc;
  logic [fqsb_pkg::NUM_COUNTS-1:0] cnt_dec;
  logic [fqsb_pkg::NUM_COUNTS-1:0][15:0] cnt_word;

  // Elaboration checks on widths and on the register map
  if (FRAME_CNT_W < 1 || FRAME_CNT_W > fqsb_pkg::DATA_W) begin : g_bad_frame_w
    $error("FRAME_CNT_W out of range");
  end

  if (LEVEL_W < 1 || LEVEL_W > fqsb_pkg::DATA_W) begin : g_bad_level_w
    $error("LEVEL_W out of range");
  end

  if (int'(fqsb_pkg::RX_HIGH_QUEUE_HALFWORD_LEVEL_OFS) -
      int'(fqsb_pkg::RX_LOW_QUEUE_FRAME_COUNT_OFS) + 1 !=
      fqsb_pkg::NUM_COUNTS) begin : g_bad_cnt_map
    $error("Counter words do not fill their index span");
  end

  if (int'(fqsb_pkg::SCRATCH_WORD_LAST_OFS) -
      int'(fqsb_pkg::SCRATCH_WORD_FIRST_OFS) + 1 !=
      fqsb_pkg::NUM_SCRATCH) begin : g_bad_scr_map
    $error("Scratch words do not fill their index span");
  end

  if (fqsb_pkg::SCRATCH_WORD_FIRST_OFS <=
      fqsb_pkg::RX_HIGH_QUEUE_HALFWORD_LEVEL_OFS) begin : g_bad_overlap
    $error("Scratch words overlap the counter words");
  end

  if (fqsb_pkg::FIRST_LEVEL_SLOT > fqsb_pkg::NUM_COUNTS) begin : g_bad_level_slot
    $error("FIRST_LEVEL_SLOT beyond the counter slots");
  end

  if ((1 << fqsb_pkg::SCRATCH_IDX_W) < fqsb_pkg::NUM_SCRATCH) begin : g_bad_scr_idx
    $error("SCRATCH_IDX_W too narrow for the scratch words");
  end

  if (fqsb_pkg::SLOT_RX_LOW_FRAMES >= fqsb_pkg::NUM_COUNTS ||
      fqsb_pkg::SLOT_RX_HIGH_FRAMES >= fqsb_pkg::NUM_COUNTS ||
      fqsb_pkg::SLOT_TX_FRAMES >= fqsb_pkg::NUM_COUNTS ||
      fqsb_pkg::SLOT_TX_LEVEL >= fqsb_pkg::NUM_COUNTS ||
      fqsb_pkg::SLOT_RX_LOW_LEVEL >= fqsb_pkg::NUM_COUNTS ||
      fqsb_pkg::SLOT_RX_HIGH_LEVEL >= fqsb_pkg::NUM_COUNTS) begin : g_bad_slot
    $error("Counter slot outside the counter array");
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue events gathered in register order
  always_comb begin
    cnt_inc = '0;
    cnt_dec = '0;
    cnt_inc[fqsb_pkg::SLOT_RX_LOW_FRAMES] = rx_low_frame_in;
    cnt_dec[fqsb_pkg::SLOT_RX_LOW_FRAMES] = rx_low_frame_out;
    cnt_inc[fqsb_pkg::SLOT_RX_HIGH_FRAMES] = rx_high_frame_in;
    cnt_dec[fqsb_pkg::SLOT_RX_HIGH_FRAMES] = rx_high_frame_out;
    cnt_inc[fqsb_pkg::SLOT_TX_FRAMES] = tx_frame_in;
    cnt_dec[fqsb_pkg::SLOT_TX_FRAMES] = tx_frame_out;
    cnt_inc[fqsb_pkg::SLOT_TX_LEVEL] = tx_halfword_in;
    cnt_dec[fqsb_pkg::SLOT_TX_LEVEL] = tx_halfword_out;
    cnt_inc[fqsb_pkg::SLOT_RX_LOW_LEVEL] = rx_low_halfword_in;
    cnt_dec[fqsb_pkg::SLOT_RX_LOW_LEVEL] = rx_low_halfword_out;
    cnt_inc[fqsb_pkg::SLOT_RX_HIGH_LEVEL] = rx_high_halfword_in;
    cnt_dec[fqsb_pkg::SLOT_RX_HIGH_LEVEL] = rx_high_halfword_out;
  end

  ////////////////////////////////////////////////////////////////////////
  // One counter per slot; frame counts narrow, levels wide
  generate
    for (genvar i = 0; i < fqsb_pkg::NUM_COUNTS; i++) begin : g_cnt
      localparam int W = (i < fqsb_pkg::FIRST_LEVEL_SLOT) ? FRAME_CNT_W : LEVEL_W;
      logic [W-1:0] count;
      fqsb_updown_counter #(
        .WIDTH(W)
      ) u_cnt (
        .clk(clk),
        .sys_rst(sys_rst),
        .inc(cnt_inc[i]),
        .dec(cnt_dec[i]),
        .count(count)
      );
      // Upper bits read as zero
      assign cnt_word[i] = 16'(count);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Address decode; one select line per mapped word
  logic [fqsb_pkg::NUM_COUNTS-1:0] cnt_sel;
  logic [fqsb_pkg::NUM_SCRATCH-1:0] scr_sel;
  logic [fqsb_pkg::NUM_SCRATCH-1:0] scr_wr;
  logic cnt_hit;
  logic scr_hit;

  for (genvar j = 0; j < fqsb_pkg::NUM_COUNTS; j++) begin : g_cnt_sel
    assign cnt_sel[j] = (reg_addr == fqsb_pkg::RX_LOW_QUEUE_FRAME_COUNT_OFS + 8'(j));
  end

  // Counter words have no write path; only scratch words take writes
  for (genvar j = 0; j < fqsb_pkg::NUM_SCRATCH; j++) begin : g_scr_sel
    assign scr_sel[j] = (reg_addr == fqsb_pkg::SCRATCH_WORD_FIRST_OFS + 8'(j));
    assign scr_wr[j] = reg_wr_en && scr_sel[j];
  end

  assign cnt_hit = |cnt_sel;
  assign scr_hit = |scr_sel;

  ////////////////////////////////////////////////////////////////////////
  // Read data select; reads only sample, never touch the counters
  logic [15:0] cnt_rd_word;
  logic [15:0] scr_rd_word;
  logic [15:0] rd_word;

  always_comb begin
    cnt_rd_word = 16'h0000;
    for (int j = 0; j < fqsb_pkg::NUM_COUNTS; j++) begin
      if (cnt_sel[j]) begin
        cnt_rd_word = cnt_word[j];
      end
    end
  end

  always_comb begin
    scr_rd_word = 16'h0000;
    for (int j = 0; j < fqsb_pkg::NUM_SCRATCH; j++) begin
      if (scr_sel[j]) begin
        scr_rd_word = st_r.scratch_word_r[j];
      end
    end
  end

  always_comb begin
    if (cnt_hit) begin
      rd_word = cnt_rd_word;
    end else if (scr_hit) begin
      rd_word = scr_rd_word;
    end else begin
      rd_word = fqsb_pkg::UNMAPPED_READ_VAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // At least one whole frame waiting in either receive queue
  logic rx_frames_waiting;

  assign rx_frames_waiting = (cnt_word[fqsb_pkg::SLOT_RX_LOW_FRAMES] != 16'h0000) ||
                             (cnt_word[fqsb_pkg::SLOT_RX_HIGH_FRAMES] != 16'h0000);

  ////////////////////////////////////////////////////////////////////////
  // Next state; a read and a write in one cycle return the old word
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid_r = reg_rd_en;
    if (reg_rd_en) begin
      st_nxt.rdata_r = rd_word;
    end
    for (int j = 0; j < fqsb_pkg::NUM_SCRATCH; j++) begin
      if (scr_wr[j]) begin
        st_nxt.scratch_word_r[j] = reg_wdata;
      end
    end
    st_nxt.ready_r = rx_frames_waiting;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.scratch_word_r <= {fqsb_pkg::NUM_SCRATCH{fqsb_pkg::REG_RESET_VAL}};
      st_r.rdata_r <= fqsb_pkg::REG_RESET_VAL;
      st_r.rd_valid_r <= 1'b0;
      st_r.ready_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata_r;
  assign reg_rd_valid = st_r.rd_valid_r;
  assign rx_frame_ready_flag = st_r.ready_r;
endmodule // fqsb_status_bank
`default_nettype wire

// *** test/fqsb_status_bank_assertions.sv ***
// Concurrent checks on the status bank ports.
// Assumes a bind from the bench top onto fqsb_status_bank.
`timescale 1ns/1ns
`default_nettype none
module fqsb_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rd_valid,
  // Queue side
  input wire logic rx_low_frame_in,
  input wire logic rx_low_frame_out,
  input wire logic rx_frame_ready_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  lo_frm_a: assert property (reg_rd_en && reg_addr == 8'hB4 |=> !reg_rdata[15:9])
    else $error("bad top bits");
  hi_frm_a: assert property (reg_rd_en && reg_addr == 8'hB5 |=> !reg_rdata[15:9])
    else $error("bad top bits");
  tx_frm_a: assert property (reg_rd_en && reg_addr == 8'hB6 |=> !reg_rdata[15:9])
    else $error("bad top bits");
  tx_lvl_a: assert property (reg_rd_en && reg_addr == 8'hB7 |=> !reg_rdata[15:14])
    else $error("bad top bits");
  lo_lvl_a: assert property (reg_rd_en && reg_addr == 8'hB8 |=> !reg_rdata[15:14])
    else $error("bad top bits");
  hi_lvl_a: assert property (reg_rd_en && reg_addr == 8'hB9 |=> !reg_rdata[15:14])
    else $error("bad top bits");
  scratch_keep_a: assert property (reg_wr_en && reg_addr[7:2] == 6'h37 ##1
    reg_rd_en && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("scratch word lost");
  ready_flag_a: assert property (
    rx_low_frame_in && !rx_low_frame_out |-> ##2 rx_frame_ready_flag)
    else $error("ready flag late");
endmodule // fqsb_sva
`default_nettype wire

// *** test/tb_top.sv ***
// Random self-checking bench for the queue status bank.
// Assumes the package, core files and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [11:0] ev = 12'h000;
  logic [15:0] reg_rdata;
  logic reg_rd_valid;
  logic rx_frame_ready_flag;
  int miscompares = 0;
  int check_count = 0;
  int seed = int'(32'h743E7FD1);
  int cyc = 0;
  int cnt[6] = '{0, 0, 0, 0, 0, 0};
  int scr[4] = '{0, 0, 0, 0};
  logic [7:0] adr[11] = '{8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9,
    8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE0};
  fqsb_status_bank DUT (
    .clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .rx_frame_ready_flag(rx_frame_ready_flag),
    .rx_low_frame_in(ev[0]), .rx_low_frame_out(ev[1]),
    .rx_high_frame_in(ev[2]), .rx_high_frame_out(ev[3]),
    .tx_frame_in(ev[4]), .tx_frame_out(ev[5]),
    .tx_halfword_in(ev[6]), .tx_halfword_out(ev[7]),
    .rx_low_halfword_in(ev[8]), .rx_low_halfword_out(ev[9]),
    .rx_high_halfword_in(ev[10]), .rx_high_halfword_out(ev[11]));
  ////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  // Fill frame counts to saturation, wander, then drain past zero
  initial begin
    int ex;
    int k;
    bit exv;
    bit nz;
    ex = 0;
    exv = 0;
    nz = 0;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      chk("rd_valid", {15'h0, reg_rd_valid}, {15'h0, exv});
      if (exv) chk("rdata", reg_rdata, ex[15:0]);
      chk("ready", {15'h0, rx_frame_ready_flag}, {15'h0, nz});
      ev = 12'($random(seed));
      if (i < 1100) ev = ev & 12'h555;
      if (i >= 2000) ev = ev & 12'hAAA;
      k = int'($unsigned($random(seed)) % 11);
      reg_addr = adr[k];
      reg_rd_en = 1'($random(seed));
      reg_wr_en = 1'($random(seed));
      reg_wdata = 16'($random(seed));
      exv = reg_rd_en;
      nz = cnt[0] != 0 || cnt[1] != 0;
      ex = k < 6 ? cnt[k] : (k < 10 ? scr[k - 6] : 0);
      if (reg_wr_en && k >= 6 && k < 10) scr[k - 6] = int'(reg_wdata);
      for (int s = 0; s < 6; s++) begin
        if (ev[2*s] && !ev[2*s+1] && cnt[s] < (s < 3 ? 511 : 16383)) cnt[s]++;
        if (ev[2*s+1] && !ev[2*s] && cnt[s] > 0) cnt[s]--;
      end
      // Mid-run reset clears every count and scratch word
      sys_rst = (i == 1500 || i == 1501);
      if (sys_rst) begin
        exv = 0;
        nz = 0;
        cnt = '{0, 0, 0, 0, 0, 0};
        scr = '{0, 0, 0, 0};
      end
    end
    $display("random traffic test done");
    print_verdict();
  end
endmodule // tb_top
bind fqsb_status_bank fqsb_sva u_sva (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .rx_low_frame_in(rx_low_frame_in),
  .rx_low_frame_out(rx_low_frame_out), .rx_frame_ready_flag(rx_frame_ready_flag));
`default_nettype wire
